// File: hw/i2c_slave_engine.sv
// I2C slave bit engine: start/stop detect, address match, byte transfer.
// Assumes: scl/sda inputs already synchronised to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_engine
   import lsens_pkg::*;
(
   input wire logic sys_clk, // Core clock
   input wire logic reset_n, // Async reset, active low
   input wire logic scl_s, // Synchronised clock line
   input wire logic sda_s, // Synchronised data line
   input wire logic addr_bit0, // Low address bit
   input wire logic [7:0] rd_data, // Byte to send
   output logic sda_oe_n, // Low pulls data line low
   output logic wr_stb, // Received data byte
   output logic [7:0] wr_byte, // Its value
   output logic rd_stb, // Send byte consumed
   output logic first_byte, // Strobe is the first data byte
   output logic stop_det // Stop condition seen
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_WRITE = 3'b011,
      ST_READ = 3'b100,
      ST_RACK = 3'b101
   } i2c_st_e;
   i2c_st_e state_ff;
   logic scl_d_ff, sda_d_ff;
   logic [7:0] shift_ff;
   logic [3:0] cnt_ff;
   logic rnw_ff, first_ff, send_ff;
   logic scl_rise, scl_fall, start_c, stop_c;

   // Line edges and bus conditions
   assign scl_rise = scl_s & ~scl_d_ff;
   assign scl_fall = ~scl_s & scl_d_ff;
   assign start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // Delayed copies
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   // Transfer sequencer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         shift_ff <= 8'h00;
         cnt_ff <= 4'h0;
         rnw_ff <= 1'b0;
         first_ff <= 1'b0;
         send_ff <= 1'b0;
         sda_oe_n <= 1'b1;
         wr_stb <= 1'b0;
         wr_byte <= 8'h00;
         rd_stb <= 1'b0;
         first_byte <= 1'b0;
         stop_det <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         stop_det <= stop_c;
         if (start_c) begin
            state_ff <= ST_ADDR;
            cnt_ff <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            state_ff <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            unique case (state_ff)
               ST_IDLE: ;
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_s};
                     cnt_ff <= cnt_ff + 4'h1;
                  end
                  if (scl_fall && cnt_ff == 4'h8) begin
                     // Upper seven bits against own address
                     if (shift_ff[7:1] == {SLAVE_ADDR_BASE, addr_bit0}) begin
                        rnw_ff <= shift_ff[0];
                        first_ff <= 1'b1;
                        sda_oe_n <= 1'b0;
                        state_ff <= ST_ACK;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     cnt_ff <= 4'h0;
                     if (rnw_ff) begin
                        shift_ff <= rd_data;
                        sda_oe_n <= rd_data[7];
                        state_ff <= ST_READ;
                     end else begin
                        sda_oe_n <= 1'b1;
                        state_ff <= ST_WRITE;
                     end
                  end
               end
               ST_WRITE: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_s};
                     cnt_ff <= cnt_ff + 4'h1;
                  end
                  if (scl_fall && cnt_ff == 4'h8) begin
                     wr_stb <= 1'b1;
                     wr_byte <= shift_ff;
                     first_byte <= first_ff;
                     first_ff <= 1'b0;
                     sda_oe_n <= 1'b0;
                     state_ff <= ST_ACK;
                  end
               end
               ST_READ: begin
                  if (scl_rise) begin
                     cnt_ff <= cnt_ff + 4'h1;
                  end
                  if (scl_fall) begin
                     if (cnt_ff == 4'h8) begin
                        sda_oe_n <= 1'b1;
                        rd_stb <= 1'b1;
                        state_ff <= ST_RACK;
                     end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        sda_oe_n <= shift_ff[6];
                     end
                  end
               end
               ST_RACK: begin
                  // Master acknowledge low means another byte wanted
                  if (scl_rise) begin
                     send_ff <= ~sda_s;
                  end
                  if (scl_fall) begin
                     if (send_ff) begin
                        cnt_ff <= 4'h0;
                        shift_ff <= rd_data;
                        sda_oe_n <= rd_data[7];
                        state_ff <= ST_READ;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // i2c_slave_engine
`default_nettype wire

// File: hw/light_sensor_i2c_measurement_ctrl.sv
// Light sensor control: register file, measurement sequencer, timing.
// Assumes: scl/sda/addr pin are asynchronous; conversion front end
// supplies a charge-balance pulse on photon_pulse, counted here per array.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Address 1000100 or 1000101 by select pin
// - Match upper seven bits, last is direction
// - Master drives clock, either drives data
// - Receiver pulls data low on acknowledge
// - Three 8-bit registers resetting to 00h
// - Command holds value, sets operation
// - Data registers read-only, latest result
// - 01h low byte, 02h high byte
// - Start powered down, data zero
// - One-shot converts then powers down
// - Continuous overwrites with each result
// - Power-down command stops measuring
// - Internal timing 16/12/8/4-bit counter
// - External period between two restarts
// - Address bit 7 write restarts integration; code does so in external timing modes only
// - One converter, command selects array
// - Full-scale range programmable over bus
// - Bit 7 enables, zero powers down
// - Bit 6 one-shot or continuous
// - Bit 5 ambient or infrared
// - Bits 4:2 timing mode and output
module light_sensor_i2c_measurement_ctrl
   import lsens_pkg::*;
#(
   parameter int OSC_DIV = OSC_DIV_CYCLES, // Core cycles per osc tick
   parameter int ADC_W = 16 // Converter width
) (
   input wire logic sys_clk, // Core clock 10 MHz
   input wire logic reset_n, // Async reset, active low
   input wire logic scl_i, // Bus clock in
   input wire logic sda_i, // Bus data in
   output logic sda_o, // Bus data out, always low
   output logic sda_oe_n, // Low drives data low
   input wire logic addr_select_pin, // Address low bit strap
   input wire logic photon_pulse, // Charge-balance pulse from front end
   output logic ir_select, // High selects infrared array
   output logic [1:0] fullscale_sel, // Range to front end
   output logic sense_active // Front end powered
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (OSC_DIV < 1) begin : g_chk_div
      $error("OSC_DIV must be at least one");
   end
   if (ADC_W != 16) begin : g_chk_w
      $error("ADC_W must be 16");
   end

   typedef enum logic [1:0] {
      MS_OFF = 2'b00,
      MS_RUN = 2'b01,
      MS_DONE = 2'b10
   } meas_st_e;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] scl_sy_ff, sda_sy_ff, a0_sy_ff, ph_sy_ff;
   logic scl_f_ff, sda_f_ff, a0_f_ff, ph_f_ff, ph_prev_ff;

   // Three stages; change taken once last two agree
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_sy_ff <= 3'h7;
         sda_sy_ff <= 3'h7;
         a0_sy_ff <= 3'h0;
         ph_sy_ff <= 3'h0;
         scl_f_ff <= 1'b1;
         sda_f_ff <= 1'b1;
         a0_f_ff <= 1'b0;
         ph_f_ff <= 1'b0;
         ph_prev_ff <= 1'b0;
      end else begin
         scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
         sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
         a0_sy_ff <= {a0_sy_ff[1:0], addr_select_pin};
         ph_sy_ff <= {ph_sy_ff[1:0], photon_pulse};
         if (scl_sy_ff[2] == scl_sy_ff[1]) scl_f_ff <= scl_sy_ff[2];
         if (sda_sy_ff[2] == sda_sy_ff[1]) sda_f_ff <= sda_sy_ff[2];
         if (a0_sy_ff[2] == a0_sy_ff[1]) a0_f_ff <= a0_sy_ff[2];
         if (ph_sy_ff[2] == ph_sy_ff[1]) ph_f_ff <= ph_sy_ff[2];
         ph_prev_ff <= ph_f_ff;
      end
   end

   // ----------------------------------------------------------------
   // Bus engine
   // ----------------------------------------------------------------
   logic wr_stb, rd_stb, first_byte, stop_det, eng_oe_n;
   logic [7:0] wr_byte;
   logic [7:0] rd_mux;
   logic [7:0] ptr_ff;
   logic [7:0] cmd_ff;
   logic [15:0] result_ff;
   logic [15:0] rd_snap_ff;

   i2c_slave_engine u_eng (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .scl_s(scl_f_ff),
      .sda_s(sda_f_ff),
      .addr_bit0(a0_f_ff),
      .rd_data(rd_mux),
      .sda_oe_n(eng_oe_n),
      .wr_stb(wr_stb),
      .wr_byte(wr_byte),
      .rd_stb(rd_stb),
      .first_byte(first_byte),
      .stop_det(stop_det)
   );

   // Open-drain data line, registered
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_o <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         sda_o <= 1'b0;
         sda_oe_n <= eng_oe_n;
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic restart_stb;

   // Read mux, high byte from snapshot so low/high pair match
   always_comb begin
      unique case (ptr_ff)
         REG_COMMAND: rd_mux = cmd_ff;
         REG_RES_LO: rd_mux = result_ff[7:0];
         REG_RES_HI: rd_mux = rd_snap_ff[15:8];
         default: rd_mux = 8'h00;
      endcase
   end

   // Pointer, command write, restart strobe
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_ff <= 8'h00;
         cmd_ff <= CMD_RESET_VAL;
         restart_stb <= 1'b0;
      end else begin
         restart_stb <= 1'b0;
         if (wr_stb && first_byte) begin
            if (wr_byte[RESTART_ADDR_BIT]) begin
               restart_stb <= 1'b1;
            end else begin
               ptr_ff <= wr_byte;
            end
         end else if (wr_stb) begin
            // Only command takes writes; data read-only
            if (ptr_ff == REG_COMMAND) cmd_ff <= wr_byte;
            ptr_ff <= ptr_ff + 8'h01;
         end else if (rd_stb) begin
            ptr_ff <= ptr_ff + 8'h01;
         end
      end
   end

   // Snapshot taken when any byte is sent or a stop is seen
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_snap_ff <= RESULT_RESET_VAL;
      end else if (rd_stb && ptr_ff == REG_RES_LO) begin
         rd_snap_ff <= result_ff;
      end else if (rd_stb || stop_det) begin
         rd_snap_ff <= result_ff;
      end
   end

   // ----------------------------------------------------------------
   // Measurement sequencer
   // ----------------------------------------------------------------
   meas_st_e mst_ff;
   logic [2:0] timing;
   logic ext_mode, cmd_write;
   logic [$clog2(OSC_DIV+1)-1:0] div_ff;
   logic osc_tick;
   logic [16:0] tick_ff;
   logic [16:0] tick_limit;
   logic [15:0] adc_ff;
   logic [15:0] tmr_ff;
   logic conv_end;

   assign timing = cmd_ff[CMD_TIMING_HI:CMD_TIMING_LO];
   assign ext_mode = timing[2];
   assign cmd_write = wr_stb && !first_byte && ptr_ff == REG_COMMAND;

   // Internal period per resolution code
   always_comb begin
      unique case (timing[1:0])
         2'b00: tick_limit = 17'(INT16_TICKS);
         2'b01: tick_limit = 17'(INT12_TICKS);
         2'b10: tick_limit = 17'(INT8_TICKS);
         2'b11: tick_limit = 17'(INT4_TICKS);
      endcase
   end

   // End of conversion: counter full or restart strobe
   assign conv_end = mst_ff == MS_RUN &&
      (ext_mode ? restart_stb : (osc_tick && tick_ff + 17'h1 == tick_limit));

   // Oscillator tick divider
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_ff <= '0;
      end else if (div_ff == ($clog2(OSC_DIV+1))'(OSC_DIV - 1)) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + 1'b1;
      end
   end
   assign osc_tick = div_ff == ($clog2(OSC_DIV+1))'(OSC_DIV - 1);

   // State: off, running, done
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mst_ff <= MS_OFF;
      end else if (!cmd_ff[CMD_ENABLE_BIT]) begin
         mst_ff <= MS_OFF;
      end else if (cmd_write) begin
         mst_ff <= MS_RUN;
      end else if (conv_end && !cmd_ff[CMD_CONT_BIT]) begin
         mst_ff <= MS_DONE;
      end else if (mst_ff == MS_OFF) begin
         mst_ff <= MS_RUN;
      end
   end

   // Integration counters, cleared at each period start
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_ff <= 17'h0;
         adc_ff <= 16'h0;
         tmr_ff <= 16'h0;
      end else if (mst_ff != MS_RUN || conv_end || cmd_write ||
                   (ext_mode && restart_stb)) begin
         tick_ff <= 17'h0;
         adc_ff <= 16'h0;
         tmr_ff <= 16'h0;
      end else begin
         if (osc_tick) begin
            tick_ff <= tick_ff + 17'h1;
            if (tmr_ff != 16'hffff) tmr_ff <= tmr_ff + 16'h1;
         end
         if (ph_f_ff && !ph_prev_ff && adc_ff != 16'hffff) begin
            adc_ff <= adc_ff + 16'h1;
         end
      end
   end

   // Result, both bytes in one write
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_ff <= RESULT_RESET_VAL;
      end else if (conv_end) begin
         if (timing == TIM_EXT_TMR) begin
            result_ff <= tmr_ff;
         end else begin
            result_ff <= adc_ff;
         end
      end
   end

   // Front end controls
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ir_select <= 1'b0;
         fullscale_sel <= 2'b00;
         sense_active <= 1'b0;
      end else begin
         ir_select <= cmd_ff[CMD_IR_BIT];
         fullscale_sel <= cmd_ff[CMD_RANGE_HI:CMD_RANGE_LO];
         sense_active <= mst_ff == MS_RUN;
      end
   end
endmodule // light_sensor_i2c_measurement_ctrl
`default_nettype wire

// File: hw/lsens_pkg.sv
// Package: register map, command fields, address and timing constants.
// Assumes: shared by the measurement core and its I2C slave engine.
package lsens_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_COMMAND = 8'h00;
   localparam logic [7:0] REG_RES_LO = 8'h01;
   localparam logic [7:0] REG_RES_HI = 8'h02;
   localparam logic [7:0] CMD_RESET_VAL = 8'h00;
   localparam logic [15:0] RESULT_RESET_VAL = 16'h0000;
   localparam int RESTART_ADDR_BIT = 7;
   // ----------------------------------------------------------------
   // Command fields
   // ----------------------------------------------------------------
   localparam int CMD_ENABLE_BIT = 7;
   localparam int CMD_CONT_BIT = 6;
   localparam int CMD_IR_BIT = 5;
   localparam int CMD_TIMING_HI = 4;
   localparam int CMD_TIMING_LO = 2;
   localparam int CMD_RANGE_HI = 1;
   localparam int CMD_RANGE_LO = 0;
   localparam logic [2:0] TIM_INT16 = 3'h0;
   localparam logic [2:0] TIM_INT12 = 3'h1;
   localparam logic [2:0] TIM_INT8 = 3'h2;
   localparam logic [2:0] TIM_INT4 = 3'h3;
   localparam logic [2:0] TIM_EXT_ADC = 3'h4;
   localparam logic [2:0] TIM_EXT_TMR = 3'h5;
   // ----------------------------------------------------------------
   // Slave address, upper six bits fixed, bit 0 from the select pin
   // ----------------------------------------------------------------
   localparam logic [5:0] SLAVE_ADDR_BASE = 6'h22;
   // ----------------------------------------------------------------
   // Timing: core clock 10 MHz, internal oscillator 725 kHz
   // ----------------------------------------------------------------
   localparam int SYS_CLK_KHZ = 10000;
   localparam int OSC_KHZ = 725;
   localparam int OSC_DIV_CYCLES = SYS_CLK_KHZ / OSC_KHZ;
   localparam int INT16_TICKS = 65536;
   localparam int INT12_TICKS = 4096;
   localparam int INT8_TICKS = 256;
   localparam int INT4_TICKS = 16;
endpackage

// File: testbench/i2c_bus_master.sv
// Behavioural bus master: start, stop, byte write and read.
// Assumes: data line has a pull-up; bus clock 800 ns, idle high.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
   input wire logic sys_clk, // Pacing clock
   input wire logic sda_i, // Resolved data line
   output logic scl, // Bus clock, master only
   output logic sda_rel // High releases data line
);
   // Bus idle at time zero
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic waitc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Data falls while clock high, then clock low
   task automatic start();
      waitc(1);
      sda_rel <= 1'b0;
      waitc(2);
      scl <= 1'b0;
      waitc(2);
   endtask
   // One bit slot; six low cycles cover the slave's output lag
   task automatic bit_slot(input logic b, output logic s);
      sda_rel <= b;
      waitc(4);
      scl <= 1'b1;
      waitc(2);
      s = sda_i;
      scl <= 1'b0;
      waitc(2);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
      bit_slot(1'b1, s);
      ack = !s;
   endtask
   // Master acknowledges all but the last byte
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         b[i] = s;
      end
      bit_slot(last, s);
   endtask
   // Data rises while clock high; clock then stands still
   task automatic stop();
      sda_rel <= 1'b0;
      waitc(2);
      scl <= 1'b1;
      waitc(4);
      sda_rel <= 1'b1;
      waitc(4);
   endtask
endmodule // i2c_bus_master
`default_nettype wire

// File: testbench/light_sensor_i2c_measurement_ctrl_tb.sv
// Testbench for the light sensor control block.
// Assumes: oscillator divider set to 1, pull-up on the data line.
`timescale 1ns/1ps
`default_nettype none
module light_sensor_i2c_measurement_ctrl_tb;
   logic sys_clk, reset_n, pin, photon;
   wire logic scl, sda_rel, sda, sda_o, sda_oe_n, ir_sel, active;
   wire logic [1:0] range;
   logic [7:0] adw;
   int bad_count, checks, act;
   assign sda = sda_rel & (sda_oe_n | sda_o); // Wired AND, pull-up
   assign adw = {6'h22, pin, 1'b0};
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Cycles with the front end powered
   always @(posedge sys_clk) if (active === 1'b1) act++;
   i2c_bus_master u_mst (.sys_clk(sys_clk), .sda_i(sda), .scl(scl),
      .sda_rel(sda_rel));
   light_sensor_i2c_measurement_ctrl #(.OSC_DIV(1)) u_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_select_pin(pin),
      .photon_pulse(photon), .ir_select(ir_sel), .fullscale_sel(range),
      .sense_active(active));
   task automatic chk(input string nm, input logic [15:0] e,
         input logic [15:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ptr(input logic [7:0] a);
      logic k;
      u_mst.start();
      u_mst.wbyte(adw, k);
      chk("ack addr", 16'h1, {15'h0, k});
      u_mst.wbyte(a, k);
      chk("ack ptr", 16'h1, {15'h0, k});
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic k;
      ptr(a);
      u_mst.wbyte(d, k);
      chk("ack data", 16'h1, {15'h0, k});
      u_mst.stop();
   endtask
   task automatic rd_n(input logic [7:0] a, input int n,
         output logic [15:0] v);
      logic k;
      logic [7:0] b;
      v = 16'h0000;
      ptr(a);
      u_mst.stop();
      u_mst.start();
      u_mst.wbyte(adw | 8'h01, k);
      chk("ack read addr", 16'h1, {15'h0, k});
      for (int i = 0; i < n; i++) begin
         u_mst.rbyte(i == n - 1, b);
         v[8*i +: 8] = b;
      end
      u_mst.stop();
   endtask
   task automatic strobe();
      ptr(8'h80);
      u_mst.stop();
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         photon <= 1'b1;
         u_mst.waitc(4);
         photon <= 1'b0;
         u_mst.waitc(12);
      end
   endtask
   task automatic t_reset();
      logic [15:0] v;
      for (int a = 0; a < 4; a++) begin
         rd_n(a[7:0], 1, v);
         chk("reg after reset", 16'h0, v);
      end
      chk("active after reset", 16'h0, {15'h0, active});
      $display("t_reset done");
   endtask
   task automatic t_addr();
      logic k;
      logic [15:0] v;
      u_mst.start();
      u_mst.wbyte(8'h8a, k);
      u_mst.stop();
      chk("ack other addr", 16'h0, {15'h0, k});
      pin <= 1'b1;
      u_mst.waitc(10);
      u_mst.start();
      u_mst.wbyte(8'h89, k);
      u_mst.stop();
      chk("ack other read", 16'h0, {15'h0, k});
      reg_wr(8'h00, 8'h03);
      rd_n(8'h00, 1, v);
      chk("cmd strap high", 16'h3, v);
      pin <= 1'b0;
      u_mst.waitc(10);
      $display("t_addr done");
   endtask
   task automatic t_cmd();
      logic [7:0] c;
      logic [15:0] v;
      for (int m = 0; m < 6; m++) begin
         c = {2'h0, m[0], m[2:0], m[1:0]};
         reg_wr(8'h00, c);
         rd_n(8'h00, 1, v);
         chk("cmd readback", {8'h0, c}, v);
         chk("ir select", {15'h0, c[5]}, {15'h0, ir_sel});
         chk("range", {14'h0, c[1:0]}, {14'h0, range});
      end
      reg_wr(8'h01, 8'hff);
      rd_n(8'h01, 1, v);
      chk("read-only low", 16'h0, v);
      $display("t_cmd done");
   endtask
   task automatic t_ext();
      logic [15:0] v;
      reg_wr(8'h00, 8'hd0);
      strobe();
      pulses(5);
      u_mst.waitc(20);
      strobe();
      rd_n(8'h01, 2, v);
      chk("ext count 5", 16'h0005, v);
      pulses(300);
      u_mst.waitc(20);
      strobe();
      rd_n(8'h01, 2, v);
      chk("ext count 300", 16'h012c, v);
      rd_n(8'h02, 1, v);
      chk("high byte", 16'h0001, v);
      $display("t_ext done");
   endtask
   task automatic t_one();
      int a0;
      logic [15:0] v;
      reg_wr(8'h00, 8'h00);
      a0 = act;
      reg_wr(8'h00, 8'h8c);
      u_mst.waitc(100);
      chk("one-shot span", 16'h1, {15'h0, (act - a0) inside {[16:24]}});
      chk("auto power-down", 16'h0, {15'h0, active});
      rd_n(8'h01, 2, v);
      chk("dark result", 16'h0, v);
      rd_n(8'h00, 1, v);
      chk("cmd held", 16'h008c, v);
      $display("t_one done");
   endtask
   task automatic t_cont();
      int a0;
      reg_wr(8'h00, 8'hcc);
      a0 = act;
      u_mst.waitc(200);
      chk("continuous", 16'h1, {15'h0, (act - a0) >= 190});
      reg_wr(8'h00, 8'h00);
      u_mst.waitc(20);
      a0 = act;
      u_mst.waitc(100);
      chk("power-down", 16'h1, {15'h0, act == a0});
      chk("active off", 16'h0, {15'h0, active});
      $display("t_cont done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      reset_n = 1'b0;
      pin = 1'b0;
      photon = 1'b0;
      bad_count = 0;
      checks = 0;
      act = 0;
      u_mst.waitc(20);
      reset_n <= 1'b1;
      u_mst.waitc(5);
      t_reset();
      t_addr();
      t_cmd();
      t_ext();
      t_one();
      t_cont();
      results();
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      results();
   end
endmodule // light_sensor_i2c_measurement_ctrl_tb
`default_nettype wire

// File: testbench/lsens_monitor.sv
// Port checker for the light sensor control block.
// Assumes: bound to the top module, sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module lsens_monitor (
   input wire logic sys_clk, // Core clock
   input wire logic reset_n, // Async reset, active low
   input wire logic scl_i, // Bus clock
   input wire logic sda_i, // Bus data
   input wire logic sda_o, // Data out
   input wire logic sda_oe_n, // Low pulls data low
   input wire logic addr_select_pin, // Address strap
   input wire logic photon_pulse, // Front end pulses
   input wire logic ir_select, // Array select
   input wire logic [1:0] fullscale_sel, // Range select
   input wire logic sense_active // Front end on
);
   logic scl_d_ff;
   logic [5:0] quiet_ff;
   // Cycles since the bus clock last moved
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d_ff <= 1'b1;
         quiet_ff <= 6'h00;
      end else begin
         scl_d_ff <= scl_i;
         if (scl_i != scl_d_ff) quiet_ff <= 6'h00;
         else if (quiet_ff != 6'h3f) quiet_ff <= quiet_ff + 6'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_bus_idle;
      scl_i [*8];
   endsequence
   sequence s_front_quiet;
      !sense_active [*8];
   endsequence
   a_data_low_only: assert property (sda_o == 1'b0)
      else $error("data out not low");
   a_idle_released: assert property (s_bus_idle |-> sda_oe_n)
      else $error("data pulled on idle bus");
   a_reset_quiet: assert property ($rose(reset_n) |-> s_front_quiet)
      else $error("front end on after reset");
   a_pins_reset: assert property ($rose(reset_n) |->
      (fullscale_sel == 2'h0) && !ir_select)
      else $error("select pins not cleared");
   a_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*4])
      else $error("data pull too short");
   a_ir_bus_only: assert property ($changed(ir_select) |->
      quiet_ff < 6'h14)
      else $error("array select moved without bus");
   a_range_bus_only: assert property ($changed(fullscale_sel) |->
      quiet_ff < 6'h14)
      else $error("range moved without bus");
   a_oe_bus_active: assert property (!sda_oe_n |-> quiet_ff < 6'h10)
      else $error("data pulled with bus clock still");
endmodule // lsens_monitor
bind light_sensor_i2c_measurement_ctrl lsens_monitor u_mon (
   .sys_clk(sys_clk), .reset_n(reset_n), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_select_pin(addr_select_pin),
   .photon_pulse(photon_pulse), .ir_select(ir_select),
   .fullscale_sel(fullscale_sel), .sense_active(sense_active));
`default_nettype wire
